//--- core/fts_regs.vh
// Constants for the flow-through SRAM pin control block.
// Included by the pin control core; definitions only.
`ifndef FTS_REGS_VH
`define FTS_REGS_VH
// Default geometry
`define FTS_ADDR_W      20
`define FTS_LANES       4
`define FTS_BYTE_W      8
`define FTS_DEPTH       1024
// Burst counter field: low address bits
`define FTS_BURST_LSB   0
`define FTS_BURST_W     2
// Reset values
`define FTS_BURST_RST   2'h0
// Sleep entry delay in cycles after sleep request seen
`define FTS_SLEEP_CYC   2
`endif

//--- core/fts_skid.v
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fts_skid #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // Fill side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // Drain side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;

  // Honest full and empty
  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointers, count and storage
  always @(posedge clk_i) begin
    if (rst_i) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data_i;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

//--- core/fts_sram_ctl.v
// Flow-through burst SRAM core: pin control, burst counter, storage.
// Assumes all synchronous pins come from the controller on clk_i.
// Asynchronous pins (output enable, sleep) are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "fts_regs.vh"
// Overview of operation
// - Advance high with clock gate low steps the burst counter.
// - Advance low on a qualified edge loads the presented address.
// - Inputs captured on rising edge, acted on only when clock gate low.
// - Selected only when both low selects low and high select high.
// - Clock gate high freezes access state and burst counter, not the write buffer drain; does not deselect.
// - Output enable low lets data and parity drive; high makes them inputs.
// - Outputs off during write data, first cycle after deselect, deselected.
// - Sleep request high enters data-keeping sleep; low in normal use.
// - Write data captured into input register on rising edge.
// - Read drives data of address sampled at the previous edge.
// - Parity lanes act as data; each gated by its byte write.
// - Two low address bits seed a two-bit burst counter.
// - Strap low selects linear burst, high selects interleaved.
module fts_sram_ctl #(
  parameter AW    = `FTS_ADDR_W,
  parameter LANES = `FTS_LANES,
  parameter BW    = `FTS_BYTE_W,
  parameter DEPTH = `FTS_DEPTH
) (
  // Clock and reset
  input  wire                  clk_i,
  input  wire                  rst_i,
  // Synchronous controls
  input  wire                  clock_gate_n_i,
  input  wire                  advance_or_load_i,
  input  wire                  select_low_a_n_i,
  input  wire                  select_low_b_n_i,
  input  wire                  select_high_i,
  input  wire                  write_strobe_n_i,
  input  wire [LANES-1:0]      byte_lane_write_n_i,
  input  wire [AW-1:0]         addr_i,
  input  wire                  burst_linear_n_i,
  // Asynchronous controls
  input  wire                  output_drive_enable_n_i,
  input  wire                  sleep_request_i,
  // Data and parity lanes
  input  wire [LANES*BW-1:0]   data_in_i,
  output reg  [LANES*BW-1:0]   data_out_o,
  output wire [LANES*BW-1:0]   data_oe_o,
  input  wire [LANES-1:0]      parity_lines_in_i,
  output reg  [LANES-1:0]      parity_lines_out_o,
  output wire [LANES-1:0]      parity_lines_oe_o,
  // Status
  output wire                  asleep_o,
  output wire                  write_stall_o
);
  localparam LW = LANES * (BW + 1);
  localparam BRW = `FTS_BURST_W;

  // Access phase states
  localparam ST_IDLE  = 3'b001;
  localparam ST_READ  = 3'b010;
  localparam ST_WRITE = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the asynchronous pins
  reg  [1:0] oe_sync_q;
  reg  [1:0] zz_sync_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      oe_sync_q <= 2'h3;
      zz_sync_q <= 2'h0;
    end else begin
      oe_sync_q <= {oe_sync_q[0], output_drive_enable_n_i};
      zz_sync_q <= {zz_sync_q[0], sleep_request_i};
    end
  end
  wire oe_n_s  = oe_sync_q[1];
  wire sleep_s = zz_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Qualified edge and select decode
  wire qual  = ~clock_gate_n_i & ~sleep_s;
  wire sel   = ~select_low_a_n_i & ~select_low_b_n_i & select_high_i;

  reg  [2:0]       state_q;
  reg  [AW-1:0]    base_q;
  reg  [BRW-1:0]   seed_q;
  reg  [BRW-1:0]   cnt_q;
  reg              first_q;
  reg              sleep_q;
  reg  [LANES-1:0] bw_n_q;

  // Burst address: wrap inside the four-location group
  wire [BRW-1:0] cnt_inc = cnt_q + 2'h1;
  wire [BRW-1:0] low_bits = burst_linear_n_i ? (seed_q ^ cnt_q)
                                             : (seed_q + cnt_q);
  wire [AW-1:0]  cur_addr = {base_q[AW-1:BRW], low_bits};

  ////////////////////////////////////////////////////////////////////////////
  // Access state machine and burst counter
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      base_q  <= {AW{1'b0}};
      seed_q  <= `FTS_BURST_RST;
      cnt_q   <= `FTS_BURST_RST;
      first_q <= 1'b0;
      bw_n_q  <= {LANES{1'b1}};
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_s;
      if (qual) begin
        if (!advance_or_load_i) begin
          if (sel) begin
            base_q  <= addr_i;
            seed_q  <= addr_i[`FTS_BURST_LSB +: BRW];
            cnt_q   <= `FTS_BURST_RST;
            bw_n_q  <= byte_lane_write_n_i;
            first_q <= (state_q == ST_IDLE);
            state_q <= write_strobe_n_i ? ST_READ : ST_WRITE;
          end else begin
            first_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end else begin
          first_q <= 1'b0;
          if (state_q != ST_IDLE) begin
            cnt_q  <= cnt_inc;
            bw_n_q <= byte_lane_write_n_i;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data path through the two-entry buffer
  reg  [LW-1:0] wr_word;
  integer       i;
  always @* begin
    wr_word = {LW{1'b0}};
    for (i = 0; i < LANES; i = i + 1) begin
      wr_word[i*(BW+1) +: BW] = data_in_i[i*BW +: BW];
      wr_word[i*(BW+1) + BW]  = parity_lines_in_i[i];
    end
  end

  wire          wr_valid = qual & (state_q == ST_WRITE);
  wire          wb_in_ready;
  wire          wb_out_valid;
  wire [LW+LANES+AW-1:0] wb_out;
  // Memory write only when the buffer really hands a word over
  wire          wb_pop = wb_out_valid & ~sleep_s;

  fts_skid #(
    .W (LW + LANES + AW)
  ) u_wbuf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_valid),
    .in_ready_o  (wb_in_ready),
    .in_data_i   ({wr_word, bw_n_q, cur_addr}),
    .out_valid_o (wb_out_valid),
    .out_ready_i (~sleep_s),
    .out_data_o  (wb_out)
  );
  assign write_stall_o = ~wb_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Storage, per-lane byte writes
  reg  [LW-1:0] mem_q [0:DEPTH-1];
  wire [AW-1:0] wb_addr = wb_out[AW-1:0];
  wire [LANES-1:0] wb_bw_n = wb_out[AW +: LANES];
  wire [LW-1:0] wb_data = wb_out[AW+LANES +: LW];
  integer       j;
  always @(posedge clk_i) begin
    if (wb_pop) begin
      for (j = 0; j < LANES; j = j + 1) begin
        if (!wb_bw_n[j])
          mem_q[wb_addr % DEPTH][j*(BW+1) +: BW+1] <= wb_data[j*(BW+1) +: BW+1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow-through read data, registered from the current address
  wire [LW-1:0] rd_word = mem_q[cur_addr % DEPTH];
  integer       k;
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_out_o         <= {LANES*BW{1'b0}};
      parity_lines_out_o <= {LANES{1'b0}};
    end else begin
      for (k = 0; k < LANES; k = k + 1) begin
        data_out_o[k*BW +: BW]  <= rd_word[k*(BW+1) +: BW];
        parity_lines_out_o[k]   <= rd_word[k*(BW+1) + BW];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive: masked on write, first cycle, deselect, sleep
  wire drive = ~oe_n_s & (state_q == ST_READ) & ~first_q & ~sleep_q;
  assign data_oe_o         = {LANES*BW{drive}};
  assign parity_lines_oe_o = {LANES{drive}};
  assign asleep_o          = sleep_q;
endmodule
`default_nettype wire

//--- testbench/fts_sram_sva.sv
// Checker for the SRAM pin control: drive masking, gating, sleep.
// Bound to the core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fts_sram_sva #(
  parameter LANES = 4,
  parameter BW    = 8
) (
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // Controls
  input wire logic                clock_gate_n_i,
  input wire logic                advance_or_load_i,
  input wire logic                select_low_a_n_i,
  input wire logic                select_low_b_n_i,
  input wire logic                select_high_i,
  input wire logic                write_strobe_n_i,
  input wire logic                output_drive_enable_n_i,
  input wire logic                sleep_request_i,
  // Outputs
  input wire logic                asleep_o,
  input wire logic [LANES*BW-1:0] data_out_o,
  input wire logic [LANES*BW-1:0] data_oe_o,
  input wire logic [LANES-1:0]    parity_lines_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Decoded pin states
  wire logic sel = !select_low_a_n_i && !select_low_b_n_i && select_high_i;
  wire logic ld  = !clock_gate_n_i && !advance_or_load_i;
  wire logic rd  = ld && sel && write_strobe_n_i && !asleep_o;
  wire logic adv = !clock_gate_n_i && advance_or_load_i && !output_drive_enable_n_i;
  // Read data lags the address by one edge, so a gated edge shows one edge later
  a_gate_holds_out: assert property (clock_gate_n_i |-> ##2 $stable(data_out_o))
    else $error("data out moved on a gated edge");
  a_desel_no_drive: assert property (ld && !sel |=> data_oe_o == '0)
    else $error("drive while deselected");
  a_first_cycle_mask: assert property ((ld && !sel) ##1 rd |=> data_oe_o == '0)
    else $error("drive in first cycle after deselect");
  a_gated_first_mask: assert property ((ld && !sel) ##1 rd ##1 clock_gate_n_i |=> data_oe_o == '0)
    else $error("gated edge ended the first cycle");
  a_write_no_drive: assert property (ld && sel && !write_strobe_n_i |=> data_oe_o == '0)
    else $error("drive during write data");
  a_oe_high_off: assert property (output_drive_enable_n_i [*3] |-> data_oe_o == '0)
    else $error("drive with enable high");
  a_read_drives: assert property (rd ##1 adv [*2] |=> data_oe_o[0])
    else $error("no drive during read burst");
  a_parity_oe_same: assert property (parity_lines_oe_o == {LANES{data_oe_o[0]}} && data_oe_o == {LANES*BW{data_oe_o[0]}})
    else $error("parity and data enables differ");
  a_sleep_enter: assert property (sleep_request_i [*8] |-> asleep_o)
    else $error("sleep not entered");
  a_sleep_quiet: assert property (asleep_o |-> data_oe_o == '0)
    else $error("drive while asleep");
endmodule
`default_nettype wire

//--- testbench/fts_host.sv
// Host controller model: one cycle of synchronous pin drives per call.
// Assumes the caller calls op once per clock with no gaps.
`timescale 1ns/1ps
`default_nettype none
module fts_host (
  // Clock
  input  wire logic        clk_i,
  // Pin drives
  output var  logic        gate_n_o = 1'b0,
  output var  logic        adv_o    = 1'b0,
  output var  logic [2:0]  sel_o    = 3'h0,
  output var  logic        we_n_o   = 1'b1,
  output var  logic [3:0]  be_n_o   = 4'hf,
  output var  logic [19:0] addr_o   = 20'h0,
  output var  logic [35:0] dq_o     = 36'h0
);
  logic wr_q = 1'b0;
  // Kinds: 0 deselect, 1 read load, 2 write load, 3 advance, 4 gated
  task automatic op(input int k, input logic [19:0] a, input logic [35:0] d,
                    input logic [3:0] b);
    @(posedge clk_i);
    gate_n_o <= (k == 4);
    adv_o    <= (k >= 3);
    sel_o    <= k ? 3'h1 : 3'($urandom_range(2, 8));
    we_n_o   <= (k != 2);
    addr_o   <= a;
    // Word only in the data phase, else the lines keep moving
    // Byte enables travel with the write command
    be_n_o   <= (k == 2) ? b : 4'hf;
    dq_o     <= wr_q ? d : ~dq_o;
    if (k != 4)
      wr_q <= (k == 2);
  endtask
endmodule
`default_nettype wire

//--- testbench/flowthrough_sram_pin_control_tb_top.sv
// Bench for the SRAM pin control: writes, bursts, gating, sleep.
// Host model drives synchronous pins except the burst strap; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module flowthrough_sram_pin_control_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, output_drive_enable_n_i = 1'b0;
  logic        sleep_request_i = 1'b0, burst_linear_n_i = 1'b0, asleep_o, write_stall_o;
  logic        clock_gate_n_i, advance_or_load_i, write_strobe_n_i;
  logic        select_low_a_n_i, select_low_b_n_i, select_high_i;
  logic [3:0]  byte_lane_write_n_i, parity_lines_in_i, parity_lines_out_o, parity_lines_oe_o;
  logic [19:0] addr_i;
  logic [31:0] data_in_i, data_out_o, data_oe_o;
  logic [35:0] mem [16];
  int          n_mismatch = 0, checked = 0;
  fts_host host (.clk_i(clk_i), .gate_n_o(clock_gate_n_i), .adv_o(advance_or_load_i),
    .sel_o({select_low_a_n_i, select_low_b_n_i, select_high_i}), .we_n_o(write_strobe_n_i),
    .be_n_o(byte_lane_write_n_i), .addr_o(addr_i), .dq_o({parity_lines_in_i, data_in_i}));
  fts_sram_ctl dut (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .clock_gate_n_i          (clock_gate_n_i),
    .advance_or_load_i       (advance_or_load_i),
    .select_low_a_n_i        (select_low_a_n_i),
    .select_low_b_n_i        (select_low_b_n_i),
    .select_high_i           (select_high_i),
    .write_strobe_n_i        (write_strobe_n_i),
    .byte_lane_write_n_i     (byte_lane_write_n_i),
    .addr_i                  (addr_i),
    .burst_linear_n_i        (burst_linear_n_i),
    .output_drive_enable_n_i (output_drive_enable_n_i),
    .sleep_request_i         (sleep_request_i),
    .data_in_i               (data_in_i),
    .data_out_o              (data_out_o),
    .data_oe_o               (data_oe_o),
    .parity_lines_in_i       (parity_lines_in_i),
    .parity_lines_out_o      (parity_lines_out_o),
    .parity_lines_oe_o       (parity_lines_oe_o),
    .asleep_o                (asleep_o),
    .write_stall_o           (write_stall_o)
  );
  // Clock and watchdog
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
  // Burst address and byte merge expectations
  function automatic logic [3:0] nxt(logic [3:0] a, int n);
    return {a[3:2], burst_linear_n_i ? a[1:0] ^ 2'(n) : a[1:0] + 2'(n)};
  endfunction
  function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] d, logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      if (!b[i]) begin
        o[i*8+:8] = d[i*8+:8];
        o[32+i]   = d[32+i];
      end
    end
    return o;
  endfunction
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [35:0] d, pd;
    logic [3:0]  b, pb, pa, x, a;
    void'($urandom(32'h4f63));
    repeat (6) host.op(0, 20'h0, 36'h0, 4'h0);
    rst_i <= 1'b0;
    x = 4'($urandom);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 17; i++) begin
        d = {4'($urandom), $urandom};
        b = p ? 4'($urandom) : 4'h0;
        host.op(i < 16 ? 2 : 0, {16'h0, 4'(i) ^ x}, pd, b);
        if (i > 0)
          mem[pa] = mrg(mem[pa], pd, pb);
        pd = d;
        pb = b;
        pa = 4'(i) ^ x;
      end
    end
    sleep_request_i <= 1'b1;
    repeat (10) host.op(0, 20'h0, 36'h0, 4'h0);
    @(negedge clk_i);
    chk({35'h0, asleep_o}, 36'h1);
    chk({35'h0, write_stall_o}, 36'h0);
    host.op(0, 20'h0, 36'h0, 4'h0);
    sleep_request_i <= 1'b0;
    repeat (6) host.op(0, 20'h0, 36'h0, 4'h0);
    for (int r = 0; r < 4; r++) begin
      host.op(0, 20'h0, 36'h0, 4'h0);
      burst_linear_n_i <= r[0] ^ r[1];
      output_drive_enable_n_i <= r[1];
      a = 4'($urandom);
      host.op(1, {16'h0, a}, 36'h0, 4'h0);
      host.op(r[0] ? 1 : 4, {16'h0, a}, 36'h0, 4'h0);
      host.op(3, 20'h0, 36'h0, 4'h0);
      for (int n = 0; n < 4; n++) begin
        host.op(n < 2 ? 3 : 0, 20'h0, 36'h0, 4'h0);
        @(negedge clk_i);
        chk({parity_lines_out_o, data_out_o}, mem[nxt(a, n)]);
        chk({parity_lines_oe_o, data_oe_o}, {36{!r[1] && n < 3}});
      end
    end
    complete_run();
  end
endmodule
bind fts_sram_ctl fts_sram_sva #(.LANES(LANES), .BW(BW)) u_sva (
  .clk_i                   (clk_i),
  .rst_i                   (rst_i),
  .clock_gate_n_i          (clock_gate_n_i),
  .advance_or_load_i       (advance_or_load_i),
  .select_low_a_n_i        (select_low_a_n_i),
  .select_low_b_n_i        (select_low_b_n_i),
  .select_high_i           (select_high_i),
  .write_strobe_n_i        (write_strobe_n_i),
  .output_drive_enable_n_i (output_drive_enable_n_i),
  .sleep_request_i         (sleep_request_i),
  .asleep_o                (asleep_o),
  .data_out_o              (data_out_o),
  .data_oe_o               (data_oe_o),
  .parity_lines_oe_o       (parity_lines_oe_o)
);
`default_nettype wire
